// ==== hsf_pkg.sv ====
/*
  Package of the hot swap status and fault register bank.
  Holds register offsets, field positions, reset values and the carrier structs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hsf_pkg;

  // Register offsets on the byte-wide management register port.
  localparam logic [7:0] HSF_OFS_SYSTEM_STATE = 8'h00;
  localparam logic [7:0] HSF_OFS_CONVERTER_STATE = 8'h01;
  localparam logic [7:0] HSF_OFS_PIN_LEVELS = 8'h02;
  localparam logic [7:0] HSF_OFS_LIVE_FAULTS = 8'h03;
  localparam logic [7:0] HSF_OFS_LATCHED_FAULTS = 8'h04;

  // Reset value of the latched fault register.
  localparam logic [7:0] HSF_LATCHED_RST = 8'h00;
  // Value returned for an offset this bank does not own.
  localparam logic [7:0] HSF_UNMAPPED_DATA = 8'h00;

  // Field positions of the latched fault register.
  localparam int HSF_LF_EXT = 7;
  localparam int HSF_LF_SHORT = 6;
  localparam int HSF_LF_DROPPED = 5;
  localparam int HSF_LF_PGI = 4;
  localparam int HSF_LF_DEGRADED = 3;
  localparam int HSF_LF_OC = 2;
  localparam int HSF_LF_UNDER = 1;
  localparam int HSF_LF_OVER = 0;

  // Field position of the channel label in the converter state register.
  localparam int HSF_CH_LSB = 4;

  // Depth of the pin synchroniser.
  localparam int HSF_SYNC_STAGES = 3;

  // Number of asynchronous pins that pass the synchroniser.
  localparam int HSF_NPINS = 19;

  // Levels that come from the device pins and analog comparators.
  typedef struct packed {
    logic enable_n_pin;
    logic second_drive_pin_level;
    logic first_drive_pin_level;
    logic timer_pin_below_level;
    logic [3:0] pg_io_levels;
    logic [3:0] mixed_io_levels;
    logic switch_shorted_live;
    logic output_under_threshold;
    logic switch_degraded_live;
    logic current_limit_active;
    logic under_high_comparator_in;
    logic under_low_comparator_in;
    logic over_comparator_in;
  } hsf_pins_t;

  // Status from on-chip logic running on mclk.
  typedef struct packed {
    logic switch_commanded_on;
    logic nvm_write_busy;
    logic power_good_met;
    logic single_driver_enabled;
    logic parallel_drive_enabled;
    logic high_stress_staged_enabled;
    logic low_stress_staged_enabled;
    logic [3:0] last_converted_channel;
    logic converter_idle_snapshot;
    logic external_trouble_latched_enabled;
    logic external_trouble_latched_active_high;
    logic pg_input_enabled;
    logic pg_input_active_high;
    logic pg_check_expired;
  } hsf_core_t;

  // Register access request from the serial interface.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hsf_req_t;

endpackage

// ==== hsf_sync.sv ====
/*
  Three-stage synchroniser for a group of asynchronous pin levels.
  Assumes the pins are quasi-static; a change is accepted once stages two and three agree.
*/
`timescale 1ns/1ps
module hsf_sync
  import hsf_pkg::*;
(
  mclk,
  srst,
  pins_in,
  pins_out
);
  input wire logic mclk;
  input wire logic srst;
  input wire logic [HSF_NPINS-1:0] pins_in;
  output logic [HSF_NPINS-1:0] pins_out;

  // All state of the synchroniser in one struct.
  typedef struct packed {
    logic [HSF_NPINS-1:0] s1;
    logic [HSF_NPINS-1:0] s2;
    logic [HSF_NPINS-1:0] s3;
    logic [HSF_NPINS-1:0] held;
  } hsf_sync_st_t;

  hsf_sync_st_t st_r;
  hsf_sync_st_t st_nxt;

  // Stage one is read only by stage two; the agreement check uses stages two and three.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < HSF_NPINS; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.held[i] = st_r.s3[i];
      end
    end
  end

  // Registers the whole state; reset clears every stage.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_out = st_r.held;
endmodule

// ==== hsf_regs.sv ====
/*
  Status and latched fault register bank of a negative-voltage hot swap controller.
  Assumes a byte-wide register port driven by the management serial interface on mclk,
  core status on mclk, and pin levels asynchronous to mclk.
*/
`timescale 1ns/1ps
module hsf_regs
  import hsf_pkg::*;
(
  mclk,
  srst,
  pins,
  core,
  req,
  rdata,
  rvalid
);
  input wire logic mclk;
  input wire logic srst;
  input wire hsf_pins_t pins;
  input wire hsf_core_t core;
  input wire hsf_req_t req;
  output logic [7:0] rdata;
  output logic rvalid;

  // All state of the register bank in one struct.
  typedef struct packed {
    logic [7:0] system_state;
    logic [7:0] converter_state;
    logic [7:0] pin_levels;
    logic [7:0] live_fault_conditions;
    logic [7:0] latched_faults;
    logic pg_result;
    logic pg_seen;
    logic [7:0] rdata;
    logic rvalid;
  } hsf_st_t;

  hsf_st_t st_r;
  hsf_st_t st_nxt;
  hsf_pins_t pin_s;
  logic [HSF_NPINS-1:0] pin_raw;
  logic [HSF_NPINS-1:0] pin_clean;

  // Selects a register image by offset; unmapped offsets read a fixed value.
  function automatic logic [7:0] hsf_read(input hsf_st_t s, input logic [7:0] a);
    logic [7:0] d;
    d = HSF_UNMAPPED_DATA;
    if (a == HSF_OFS_SYSTEM_STATE) begin
      d = s.system_state;
    end else if (a == HSF_OFS_CONVERTER_STATE) begin
      d = s.converter_state;
    end else if (a == HSF_OFS_PIN_LEVELS) begin
      d = s.pin_levels;
    end else if (a == HSF_OFS_LIVE_FAULTS) begin
      d = s.live_fault_conditions;
    end else if (a == HSF_OFS_LATCHED_FAULTS) begin
      d = s.latched_faults;
    end
    return d;
  endfunction

  // Pins come from outside mclk, so they pass the shared synchroniser first.
  assign pin_raw = pins;
  assign pin_s = hsf_pins_t'(pin_clean);

  hsf_sync u_sync (
    .mclk(mclk),
    .srst(srst),
    .pins_in(pin_raw),
    .pins_out(pin_clean)
  );

  // Builds the status images, updates the latched flags and answers reads.
  always_comb begin
    logic [7:0] ev;
    logic ext_live;
    logic under_live;
    ev = 8'h00;
    st_nxt = st_r;

    st_nxt.system_state[7] = core.switch_commanded_on;
    st_nxt.system_state[6] = pin_s.enable_n_pin;
    st_nxt.system_state[5] = pin_s.second_drive_pin_level;
    st_nxt.system_state[4] = pin_s.first_drive_pin_level;
    // The comparator already signals below 0.1V; no analog level is seen here.
    st_nxt.system_state[3] = pin_s.timer_pin_below_level;
    st_nxt.system_state[2] = core.nvm_write_busy;
    st_nxt.system_state[1] = core.power_good_met;
    st_nxt.system_state[0] = core.single_driver_enabled;

    st_nxt.converter_state[HSF_CH_LSB +: 4] = core.last_converted_channel;
    st_nxt.converter_state[3] = core.converter_idle_snapshot;
    st_nxt.converter_state[2] = core.parallel_drive_enabled;
    st_nxt.converter_state[1] = core.high_stress_staged_enabled;
    st_nxt.converter_state[0] = core.low_stress_staged_enabled;

    // Index 3 of the pin vectors is pin one, so bit order matches the register.
    st_nxt.pin_levels[7:4] = pin_s.pg_io_levels;
    st_nxt.pin_levels[3:0] = pin_s.mixed_io_levels;

    // The external fault input is live only when the fourth pin is so configured.
    ext_live = core.external_trouble_latched_enabled &&
      (pin_s.pg_io_levels[0] == core.external_trouble_latched_active_high);
    // The power-good input result is sampled once, at check timer expiry.
    if (core.pg_input_enabled && core.pg_check_expired) begin
      st_nxt.pg_result = (pin_s.pg_io_levels[1] != core.pg_input_active_high);
    end else if (!core.pg_input_enabled) begin
      st_nxt.pg_result = 1'b0;
    end
    under_live = !pin_s.under_high_comparator_in && !pin_s.under_low_comparator_in;

    st_nxt.live_fault_conditions[7] = ext_live;
    st_nxt.live_fault_conditions[6] = pin_s.switch_shorted_live;
    st_nxt.live_fault_conditions[5] = pin_s.output_under_threshold;
    st_nxt.live_fault_conditions[4] = st_r.pg_result;
    st_nxt.live_fault_conditions[3] = pin_s.switch_degraded_live;
    st_nxt.live_fault_conditions[2] = pin_s.current_limit_active;
    st_nxt.live_fault_conditions[1] = under_live;
    st_nxt.live_fault_conditions[0] = pin_s.over_comparator_in;

    // Power good is remembered so a later output drop counts as a failure.
    if (core.power_good_met) begin
      st_nxt.pg_seen = 1'b1;
    end

    // Events other than the power-good input raise their latched flag on the rising edge of the live condition.
    ev[HSF_LF_EXT] = ext_live && !st_r.live_fault_conditions[7];
    ev[HSF_LF_SHORT] = pin_s.switch_shorted_live && !st_r.live_fault_conditions[6];
    // Only the fall of the output counts, so a steady low output cannot re-raise the flag.
    ev[HSF_LF_DROPPED] = st_r.pg_seen && pin_s.output_under_threshold &&
      !st_r.live_fault_conditions[5];
    ev[HSF_LF_PGI] = core.pg_input_enabled && core.pg_check_expired &&
      (pin_s.pg_io_levels[1] != core.pg_input_active_high);
    ev[HSF_LF_DEGRADED] = pin_s.switch_degraded_live && !st_r.live_fault_conditions[3];
    ev[HSF_LF_OC] = pin_s.current_limit_active && !st_r.live_fault_conditions[2];
    ev[HSF_LF_UNDER] = under_live && !st_r.live_fault_conditions[1];
    ev[HSF_LF_OVER] = pin_s.over_comparator_in && !st_r.live_fault_conditions[0];

    // Once a drop is recorded, power good must be seen again before another one.
    if (ev[HSF_LF_DROPPED]) begin
      st_nxt.pg_seen = 1'b0;
    end

    // Host writes clear only the bits written as zero; a same-cycle event wins.
    if (req.wr && req.addr == HSF_OFS_LATCHED_FAULTS) begin
      st_nxt.latched_faults = (st_r.latched_faults & req.wdata) | ev;
    end else begin
      st_nxt.latched_faults = st_r.latched_faults | ev;
    end
    // Writes to any other offset fall through with no effect.

    // Read data registered one cycle after the request.
    st_nxt.rvalid = req.rd;
    if (req.rd) begin
      st_nxt.rdata = hsf_read(st_r, req.addr);
    end
  end

  // Registers the whole state; latched flags reset to zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
      st_r.latched_faults <= HSF_LATCHED_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;
endmodule

// ==== hsf_regs_sva.sv ====
/* Assertions on the ports of the status and fault register bank.
   Assumes one mclk domain and the one-cycle read answer of the bank. */
`timescale 1ns/1ps
module hsf_regs_sva
  import hsf_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire hsf_pins_t pins,
  input wire hsf_core_t core,
  input wire hsf_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // Core and reset one cycle back, so no property needs $past on a struct.
  hsf_core_t core_q;
  logic srst_q;
  always_ff @(posedge mclk) begin
    core_q <= core;
    srst_q <= srst;
  end
  // Everything is suspended while reset is held.
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  AST_RD_ANSWER: assert property (req.rd |=> rvalid)
    else $error("read got no answer");
  AST_NO_ANSWER: assert property (!req.rd |=> !rvalid)
    else $error("answer without a read");
  AST_RDATA_HOLD: assert property (!req.rd |=> $stable(rdata))
    else $error("read data moved without a read");
  AST_SYS_CORE: assert property (
    req.rd && req.addr == HSF_OFS_SYSTEM_STATE && core == core_q && !srst_q |=>
    {rdata[7], rdata[2:0]} == {core_q.switch_commanded_on, core_q.nvm_write_busy,
    core_q.power_good_met, core_q.single_driver_enabled})
    else $error("system state core bits wrong");
  AST_CONV: assert property (
    req.rd && req.addr == HSF_OFS_CONVERTER_STATE && core == core_q && !srst_q |=>
    rdata == {core_q.last_converted_channel, core_q.converter_idle_snapshot,
    core_q.parallel_drive_enabled, core_q.high_stress_staged_enabled,
    core_q.low_stress_staged_enabled})
    else $error("converter state wrong");
  AST_UNMAPPED: assert property (
    req.rd && req.addr > HSF_OFS_LATCHED_FAULTS |=> rdata == HSF_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  AST_LATCH_RESET: assert property (
    req.rd && req.addr == HSF_OFS_LATCHED_FAULTS && srst_q |=> rdata == HSF_LATCHED_RST)
    else $error("latched faults not clear after reset");
  // Without a write between two reads no flag may vanish.
  AST_STICKY: assert property (
    (req.rd && req.addr == HSF_OFS_LATCHED_FAULTS && !req.wr) ##1
    (req.rd && req.addr == HSF_OFS_LATCHED_FAULTS) |=> ($past(rdata) & ~rdata) == 8'h00)
    else $error("latched flag cleared without a write");
endmodule
bind hsf_regs hsf_regs_sva hsf_regs_sva_i (.mclk(mclk), .srst(srst), .pins(pins),
  .core(core), .req(req), .rdata(rdata), .rvalid(rvalid));

// ==== hsf_host.sv ====
/* Host model of the management side: single-byte reads and writes.
   Assumes every call starts just after a rising mclk edge. */
`timescale 1ns/1ps
module hsf_host
  import hsf_pkg::*;
(
  input wire logic mclk,
  output hsf_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // Idle until the first call.
  initial req = '0;
  // Dropped on the taking edge, so the next call may follow back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  // A missing answer returns unknowns so that any compare fails.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask
endmodule

// ==== testbench.sv ====
/* Self-checking bench of the status and fault register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module testbench
  import hsf_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  hsf_pins_t pins = '0;
  hsf_core_t core = '0;
  hsf_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] held;
  logic [31:0] pat;
  int errors = 0;
  int checks_done = 0;
  initial begin
    forever #2 mclk = ~mclk;
  end
  hsf_host hsf_host_i (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));
  hsf_regs hsf_regs_i (.mclk(mclk), .srst(srst), .pins(pins), .core(core), .req(req),
    .rdata(rdata), .rvalid(rvalid));
  // Reads one register and compares it with the expected byte.
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    hsf_host_i.rd(a, d);
    checks_done++;
    if (d !== e) begin
      errors++;
      $display("MISMATCH t=%0t addr=%h got=%h exp=%h", $time, a, d, e);
    end
  endtask
  // Pins need four edges through the synchroniser and one more into the register image; eight give margin.
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask
  function automatic logic [7:0] conv_exp();
    return {core.last_converted_channel, core.converter_idle_snapshot,
      core.parallel_drive_enabled, core.high_stress_staged_enabled,
      core.low_stress_staged_enabled};
  endfunction
  function automatic logic [7:0] live_exp(input logic pgi);
    return {core.external_trouble_latched_enabled & (pins.pg_io_levels[0] == core.external_trouble_latched_active_high),
      pins.switch_shorted_live, pins.output_under_threshold, pgi, pins.switch_degraded_live,
      pins.current_limit_active, ~pins.under_high_comparator_in & ~pins.under_low_comparator_in,
      pins.over_comparator_in};
  endfunction
  task automatic conclude();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The sequence needs well under two thousand cycles.
  initial begin
    #40000;
    errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 srst = 1'b0;
    chk(HSF_OFS_LATCHED_FAULTS, HSF_LATCHED_RST);
    chk(8'h05, HSF_UNMAPPED_DATA);
    // Two complementary patterns catch swapped or stuck bits; status writes must not stick.
    for (int k = 0; k < 2; k++) begin
      pat = k ? 32'hAAAAAAAA : 32'h55555555;
      pins = pat[$bits(pins)-1:0];
      core = {pat[$bits(core)-1:1], 1'b0};
      for (int a = 0; a < 4; a++) hsf_host_i.wr(8'(a), 8'hFF);
      settle();
      chk(HSF_OFS_SYSTEM_STATE, {core.switch_commanded_on, pins.enable_n_pin,
        pins.second_drive_pin_level, pins.first_drive_pin_level, pins.timer_pin_below_level,
        core.nvm_write_busy, core.power_good_met, core.single_driver_enabled});
      chk(HSF_OFS_PIN_LEVELS, {pins.pg_io_levels, pins.mixed_io_levels});
      chk(HSF_OFS_LIVE_FAULTS, live_exp(1'b0));
    end
    // Every channel label reaches the converter state register.
    for (int c = 0; c < 16; c++) begin
      core.last_converted_channel = 4'(c);
      @(posedge mclk);
      #1;
      chk(HSF_OFS_CONVERTER_STATE, conv_exp());
    end
    core = '{external_trouble_latched_enabled: 1'b1, external_trouble_latched_active_high: 1'b1, pg_input_enabled: 1'b1,
      pg_input_active_high: 1'b1, default: 1'b0};
    pins = '0;
    // Mid-run reset forgets the power good seen during the patterns.
    srst = 1'b1;
    settle();
    srst = 1'b0;
    settle();
    pins.under_high_comparator_in = 1'b1;
    hsf_host_i.wr(HSF_OFS_LATCHED_FAULTS, 8'h00);
    settle();
    chk(HSF_OFS_LATCHED_FAULTS, 8'h00);
    // All live conditions except the power-good input result rise together; power good was never seen, so no drop flag.
    pins = '{pg_io_levels: 4'h1, switch_shorted_live: 1'b1, output_under_threshold: 1'b1,
      switch_degraded_live: 1'b1, current_limit_active: 1'b1, over_comparator_in: 1'b1,
      default: 1'b0};
    settle();
    chk(HSF_OFS_LATCHED_FAULTS, 8'hCF);
    hsf_host_i.wr(HSF_OFS_LATCHED_FAULTS, 8'hFE);
    chk(HSF_OFS_LATCHED_FAULTS, 8'hCE);
    pins.output_under_threshold = 1'b0;
    core.power_good_met = 1'b1;
    settle();
    pins.output_under_threshold = 1'b1;
    settle();
    hsf_host_i.rd(HSF_OFS_LATCHED_FAULTS, held);
    chk(HSF_OFS_LATCHED_FAULTS, 8'hEE);
    // Check timer expires while the third pin shows the bad level.
    core.pg_check_expired = 1'b1;
    @(posedge mclk);
    #1 core.pg_check_expired = 1'b0;
    settle();
    chk(HSF_OFS_LIVE_FAULTS, live_exp(1'b1));
    chk(HSF_OFS_LATCHED_FAULTS, 8'hFE);
    hsf_host_i.wr(HSF_OFS_LATCHED_FAULTS, 8'h00);
    chk(HSF_OFS_LATCHED_FAULTS, 8'h00);
    conclude();
  end
endmodule
